// [verilog/ccs_pkg.sv]
`default_nettype none
package ccs_pkg;

    // register bus shape
    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 8;

    // register offsets
    localparam logic [7:0]  PIN_MODE_OFFS   = 8'h00;
    localparam logic [7:0]  RUN_CTRL_OFFS   = 8'h01;
    localparam logic [7:0]  SYS_SEL_OFFS    = 8'h02;

    // clock_pin_mode_control fields
    localparam int          HS_EXT_BIT      = 7;
    localparam int          HS_OSC_BIT      = 6;
    localparam int          SUB_EXT_BIT     = 5;
    localparam int          SUB_OSC_BIT     = 4;
    localparam int          DRIVE_HI_BIT    = 2;
    localparam int          DRIVE_LO_BIT    = 1;
    localparam int          FREQ_RANGE_BIT  = 0;
    localparam logic [7:0]  PIN_MODE_MASK   = 8'hF7;
    localparam logic [7:0]  PIN_MODE_RESET  = 8'h00;

    // clock_source_run_control fields
    localparam int          HS_HALT_BIT     = 7;
    localparam int          SUB_HALT_BIT    = 6;
    localparam int          MID_EN_BIT      = 1;
    localparam int          FAST_HALT_BIT   = 0;
    localparam logic [7:0]  RUN_CTRL_MASK   = 8'hC3;
    localparam logic [7:0]  RUN_CTRL_RESET  = 8'hC0;

    // system_clock_select fields
    localparam int          CPU_STAT_BIT    = 7;
    localparam int          CPU_SEL_BIT     = 6;
    localparam int          MAIN_STAT_BIT   = 5;
    localparam int          MAIN_SEL_BIT    = 4;
    localparam int          ONCHIP_STAT_BIT = 1;
    localparam int          ONCHIP_SEL_BIT  = 0;
    localparam logic [7:0]  SYS_SEL_WMASK   = 8'h51;
    localparam logic [7:0]  SYS_SEL_RESET   = 8'h00;

    // drive mode codes
    localparam logic [1:0]  DRIVE_LOW_POWER = 2'h0;
    localparam logic [1:0]  DRIVE_NORMAL    = 2'h1;
    localparam logic [1:0]  DRIVE_ULTRA_LOW = 2'h2;
    localparam logic [1:0]  DRIVE_BARRED    = 2'h3;

    // pin mode codes
    localparam logic [1:0]  PIN_OSC_MODE    = 2'h1;
    localparam logic [1:0]  PIN_EXT_MODE    = 2'h3;

    // switchover dead time with every clock gated off
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          SW_GAP_NS       = 40;
    localparam int          SW_GAP_CYC_I    =
        (SW_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  SW_GAP_CYC      = SW_GAP_CYC_I[3:0];

    // switchover sequencer states, gray along the path
    typedef enum logic [1:0] {
        CCS_SW_IDLE  = 2'h0,
        CCS_SW_BREAK = 2'h1,
        CCS_SW_GAP   = 2'h3,
        CCS_SW_MAKE  = 2'h2
    } ccs_sw_state_t;

    // pin decode: {port_mode, ext_accept, osc_run}
    function automatic logic [2:0] ccs_pin_decode(
        input logic [1:0] mode,
        input logic       halt
    );
        logic [2:0] res;
        res = 3'h4;
        if (mode == PIN_OSC_MODE)
            res = {1'b0, 1'b0, ~halt};
        else if (mode == PIN_EXT_MODE)
            res = {1'b0, ~halt, 1'b0};
        return res;
    endfunction

endpackage
`default_nettype wire

// [verilog/ccs_sw_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ccs_sw_if;
    logic req;        // requested source, 0 or 1
    logic tgt_ready;  // requested source is running and stable
    logic sel;        // mux select in force
    logic gate;       // mux output gated off during a switchover
    logic status;     // source confirmed in use

    modport ctrl (output req, output tgt_ready,
                  input sel, input gate, input status);
    modport seq  (input req, input tgt_ready,
                  output sel, output gate, output status);
endinterface
`default_nettype wire

// [verilog/ccs_pin_mode.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_pin_mode
    import ccs_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic [1:0] mode,
    input  wire logic       halt,
    // pin function
    output logic            osc_run,
    output logic            ext_accept,
    output logic            port_mode
);
    wire logic [2:0] dec_next = ccs_pin_decode(mode, halt);

    // registered so the pad controls never see decode hazards
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            osc_run    <= 1'b0;
            ext_accept <= 1'b0;
            port_mode  <= 1'b1;
        end
        else
        begin
            osc_run    <= dec_next[0];
            ext_accept <= dec_next[1];
            port_mode  <= dec_next[2];
        end
    end
endmodule // ccs_pin_mode
`default_nettype wire

// [verilog/ccs_switch_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_switch_seq
    import ccs_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // request and mux side
    ccs_sw_if.seq     sw
);
    ccs_sw_state_t state_reg;
    logic [3:0]    gap_reg;
    logic          sel_reg;
    logic          gate_reg;
    logic          status_reg;

    // a change only starts once the new source is up
    wire logic start = (sw.req != sel_reg) && sw.tgt_ready;

    assign sw.sel    = sel_reg;
    assign sw.gate   = gate_reg;
    assign sw.status = status_reg;

    // break-before-make: gate, wait, move select, then ungate and report on one edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg  <= CCS_SW_IDLE;
            gap_reg    <= 4'h0;
            sel_reg    <= 1'b0;
            gate_reg   <= 1'b0;
            status_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                CCS_SW_IDLE:
                begin
                    if (start)
                    begin
                        gate_reg  <= 1'b1;
                        state_reg <= CCS_SW_BREAK;
                    end
                end
                CCS_SW_BREAK:
                begin
                    gap_reg   <= SW_GAP_CYC;
                    state_reg <= CCS_SW_GAP;
                end
                CCS_SW_GAP:
                begin
                    if (gap_reg <= 4'h1)
                    begin
                        sel_reg   <= ~sel_reg;
                        state_reg <= CCS_SW_MAKE;
                    end
                    else
                        gap_reg <= gap_reg - 4'h1;
                end
                CCS_SW_MAKE:
                begin
                    gate_reg   <= 1'b0;
                    status_reg <= sel_reg;
                    state_reg  <= CCS_SW_IDLE;
                end
                default:
                    state_reg <= CCS_SW_IDLE;
            endcase
        end
    end
endmodule // ccs_switch_seq
`default_nettype wire

// [verilog/ccs_clock_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_ctrl
    import ccs_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // register port
    input  wire logic [ccs_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [ccs_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [ccs_pkg::DATA_W-1:0]  reg_rdata,
    // source stability from the analog side
    input  wire logic                        hs_clock_ready,
    input  wire logic                        sub_clock_ready,
    input  wire logic                        fast_osc_ready,
    input  wire logic                        mid_osc_ready,
    // high-speed pins
    output logic                             hs_crystal_oscillator_run,
    output logic                             hs_external_accept,
    output logic                             hs_port_mode,
    output logic                             hs_freq_range,
    // subsystem pins
    output logic                             sub_crystal_oscillator_run,
    output logic                             sub_external_accept,
    output logic                             sub_port_mode,
    output logic      [1:0]                  sub_drive_mode,
    // on-chip oscillators
    output logic                             mid_osc_run,
    output logic                             fast_osc_run,
    // clock mux controls
    output logic                             onchip_mux_sel,
    output logic                             main_mux_sel,
    output logic                             cpu_mux_sel,
    output logic                             clock_gate_off
);

    // software-visible registers
    logic [7:0] pin_mode_reg;
    logic [7:0] run_ctrl_reg;
    logic [7:0] sys_sel_reg;

    // pin decode outputs from the two decoders
    logic       hs_osc_w;
    logic       hs_ext_w;
    logic       hs_port_w;
    logic       sub_osc_w;
    logic       sub_ext_w;
    logic       sub_port_w;

    // switchover sequencers: on-chip, main, cpu
    ccs_sw_if   onchip_sw ();
    ccs_sw_if   main_sw ();
    ccs_sw_if   cpu_sw ();

    // address decode
    wire logic hit_pin  = (reg_addr == PIN_MODE_OFFS);
    wire logic hit_run  = (reg_addr == RUN_CTRL_OFFS);
    wire logic hit_sel  = (reg_addr == SYS_SEL_OFFS);
    wire logic wr_pin   = reg_wr && hit_pin;
    wire logic wr_run   = reg_wr && hit_run;
    wire logic wr_sel   = reg_wr && hit_sel;

    // barred drive code keeps the old drive setting
    wire logic [1:0] drive_wr =
        {reg_wdata[DRIVE_HI_BIT], reg_wdata[DRIVE_LO_BIT]};
    wire logic       drive_bad = (drive_wr == DRIVE_BARRED);
    wire logic [1:0] drive_keep =
        {pin_mode_reg[DRIVE_HI_BIT], pin_mode_reg[DRIVE_LO_BIT]};
    wire logic [1:0] drive_new = drive_bad ? drive_keep : drive_wr;

    // next value of the pin mode register
    wire logic [7:0] pin_wr_val =
        (reg_wdata & PIN_MODE_MASK & 8'hF9) |
        {5'h00, drive_new, 1'b0};
    wire logic [7:0] pin_mode_next = wr_pin ? pin_wr_val : pin_mode_reg;

    // next value of the run control register
    wire logic [7:0] run_ctrl_next =
        wr_run ? (reg_wdata & RUN_CTRL_MASK) : run_ctrl_reg;

    // only the select bits are writable, status bits are hardware's
    wire logic [7:0] sys_sel_next =
        wr_sel ? (reg_wdata & SYS_SEL_WMASK) : sys_sel_reg;

    // field views
    wire logic [1:0] hs_mode  = {pin_mode_reg[HS_EXT_BIT],
                                 pin_mode_reg[HS_OSC_BIT]};
    wire logic [1:0] sub_mode = {pin_mode_reg[SUB_EXT_BIT],
                                 pin_mode_reg[SUB_OSC_BIT]};

    // source availability for the muxes
    wire logic fast_up = fast_osc_run && fast_osc_ready;
    wire logic mid_up  = mid_osc_run && mid_osc_ready;
    wire logic hs_up   = (hs_osc_w || hs_ext_w) && hs_clock_ready;
    wire logic sub_up  = (sub_osc_w || sub_ext_w) && sub_clock_ready;
    wire logic oco_up  = onchip_sw.sel ? mid_up : fast_up;
    wire logic main_up = main_sw.sel ? hs_up : oco_up;

    // requests into the sequencers
    assign onchip_sw.req       = sys_sel_reg[ONCHIP_SEL_BIT];
    assign onchip_sw.tgt_ready = onchip_sw.req ? mid_up : fast_up;
    assign main_sw.req         = sys_sel_reg[MAIN_SEL_BIT];
    assign main_sw.tgt_ready   = main_sw.req ? hs_up : oco_up;
    assign cpu_sw.req          = sys_sel_reg[CPU_SEL_BIT];
    assign cpu_sw.tgt_ready    = cpu_sw.req ? sub_up : main_up;

    // read mux, status bits come from the sequencers
    wire logic [7:0] sel_rd_val =
        (sys_sel_reg & SYS_SEL_WMASK) |
        ({7'h00, cpu_sw.status} << CPU_STAT_BIT) |
        ({7'h00, main_sw.status} << MAIN_STAT_BIT) |
        ({7'h00, onchip_sw.status} << ONCHIP_STAT_BIT);
    wire logic [7:0] rd_val =
        hit_pin ? pin_mode_reg :
        hit_run ? run_ctrl_reg :
        hit_sel ? sel_rd_val   : 8'h00;
    wire logic [7:0] rdata_next = reg_rd ? rd_val : 8'h00;

    // any sequencer mid-switch holds the cpu clock off
    wire logic gate_next = onchip_sw.gate || main_sw.gate || cpu_sw.gate;

    // register file
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin_mode_reg <= PIN_MODE_RESET;
            run_ctrl_reg <= RUN_CTRL_RESET;
            sys_sel_reg  <= SYS_SEL_RESET;
        end
        else
        begin
            pin_mode_reg <= pin_mode_next;
            run_ctrl_reg <= run_ctrl_next;
            sys_sel_reg  <= sys_sel_next;
        end
    end

    // read data stands for the cycle after the strobe only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_next;
    end

    // oscillator and range controls, registered for clean pad drive
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hs_freq_range  <= 1'b0;
            sub_drive_mode <= DRIVE_LOW_POWER;
            mid_osc_run    <= 1'b0;
            fast_osc_run   <= 1'b1;
        end
        else
        begin
            hs_freq_range  <= pin_mode_reg[FREQ_RANGE_BIT];
            sub_drive_mode <= drive_keep;
            mid_osc_run    <= run_ctrl_reg[MID_EN_BIT];
            fast_osc_run   <= ~run_ctrl_reg[FAST_HALT_BIT];
        end
    end

    // pin outputs, one more stage so they come from this module's flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hs_crystal_oscillator_run  <= 1'b0;
            hs_external_accept         <= 1'b0;
            hs_port_mode               <= 1'b1;
            sub_crystal_oscillator_run <= 1'b0;
            sub_external_accept        <= 1'b0;
            sub_port_mode              <= 1'b1;
        end
        else
        begin
            hs_crystal_oscillator_run  <= hs_osc_w;
            hs_external_accept         <= hs_ext_w;
            hs_port_mode               <= hs_port_w;
            sub_crystal_oscillator_run <= sub_osc_w;
            sub_external_accept        <= sub_ext_w;
            sub_port_mode              <= sub_port_w;
        end
    end

    // mux controls; the gate covers the select move on the same edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            onchip_mux_sel <= 1'b0;
            main_mux_sel   <= 1'b0;
            cpu_mux_sel    <= 1'b0;
            clock_gate_off <= 1'b0;
        end
        else
        begin
            onchip_mux_sel <= onchip_sw.sel;
            main_mux_sel   <= main_sw.sel;
            cpu_mux_sel    <= cpu_sw.sel;
            clock_gate_off <= gate_next;
        end
    end

    // high-speed pin decode, halt has no effect in port mode
    ccs_pin_mode u_hs_pins (
        .clk        (clk),
        .rst_n      (rst_n),
        .mode       (hs_mode),
        .halt       (run_ctrl_reg[HS_HALT_BIT]),
        .osc_run    (hs_osc_w),
        .ext_accept (hs_ext_w),
        .port_mode  (hs_port_w)
    );

    // subsystem pin decode
    ccs_pin_mode u_sub_pins (
        .clk        (clk),
        .rst_n      (rst_n),
        .mode       (sub_mode),
        .halt       (run_ctrl_reg[SUB_HALT_BIT]),
        .osc_run    (sub_osc_w),
        .ext_accept (sub_ext_w),
        .port_mode  (sub_port_w)
    );

    // status only moves when a switchover has completed
    ccs_switch_seq u_onchip_seq (
        .clk   (clk),
        .rst_n (rst_n),
        .sw    (onchip_sw)
    );

    ccs_switch_seq u_main_seq (
        .clk   (clk),
        .rst_n (rst_n),
        .sw    (main_sw)
    );

    ccs_switch_seq u_cpu_seq (
        .clk   (clk),
        .rst_n (rst_n),
        .sw    (cpu_sw)
    );

endmodule // ccs_clock_ctrl
`default_nettype wire

// [verif/ccs_clock_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_ctrl_chk
    import ccs_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins and oscillators
    input wire logic       hs_crystal_oscillator_run,
    input wire logic       hs_external_accept,
    input wire logic       hs_port_mode,
    input wire logic       hs_freq_range,
    input wire logic       sub_port_mode,
    input wire logic [1:0] sub_drive_mode,
    input wire logic       mid_osc_run,
    input wire logic       fast_osc_run,
    // clock mux
    input wire logic       main_mux_sel,
    input wire logic       cpu_mux_sel,
    input wire logic       clock_gate_off
);
    // decoded strobes, kept as nets so properties stay short
    wire logic pin_wr = reg_wr && reg_addr == PIN_MODE_OFFS;
    wire logic run_wr = reg_wr && reg_addr == RUN_CTRL_OFFS;
    wire logic sel_rd = reg_rd && reg_addr == SYS_SEL_OFFS;
    wire logic run_rd = reg_rd && reg_addr == RUN_CTRL_OFFS;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    rd_idle_a:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    run_fixed_a:
        assert property (run_rd |=> reg_rdata[5:2] == 4'h0)
        else $error("fixed zero bits of run control read nonzero");
    cpu_stat_a:
        assert property (sel_rd |=> reg_rdata[7] == $past(cpu_mux_sel))
        else $error("cpu status disagrees with cpu mux");
    drive_ok_a:
        assert property (sub_drive_mode != DRIVE_BARRED)
        else $error("barred drive code reached the oscillator");
    range_a:
        assert property (pin_wr |-> ##2
                         hs_freq_range == $past(reg_wdata[0], 2))
        else $error("frequency range does not follow write");
    osc_ctrl_a:
        assert property (run_wr |-> ##2 mid_osc_run == $past(reg_wdata[1], 2)
                         && fast_osc_run == !$past(reg_wdata[0], 2))
        else $error("on-chip oscillator controls do not follow write");
    hs_port_a:
        assert property (pin_wr |-> ##3
                         hs_port_mode == !$past(reg_wdata[6], 3))
        else $error("high-speed port mode wrong after write");
    sub_port_a:
        assert property (pin_wr |-> ##3
                         sub_port_mode == !$past(reg_wdata[4], 3))
        else $error("subsystem port mode wrong after write");
    hs_excl_a:
        assert property (!(hs_crystal_oscillator_run && hs_external_accept)
                         && !(hs_port_mode && hs_external_accept))
        else $error("high-speed pin functions overlap");
    gate_hold_a:
        assert property ($rose(clock_gate_off) |->
                         clock_gate_off[*4] ##[1:8] !clock_gate_off)
        else $error("switchover gate length out of bounds");
    mux_gated_a:
        assert property ($changed(main_mux_sel) || $changed(cpu_mux_sel)
                         |-> clock_gate_off)
        else $error("mux select changed while clock not gated");
endmodule // ccs_clock_ctrl_chk

bind ccs_clock_ctrl ccs_clock_ctrl_chk ccs_clock_ctrl_chk_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .hs_crystal_oscillator_run(hs_crystal_oscillator_run),
    .hs_external_accept(hs_external_accept),
    .hs_port_mode(hs_port_mode), .hs_freq_range(hs_freq_range),
    .sub_port_mode(sub_port_mode), .sub_drive_mode(sub_drive_mode),
    .mid_osc_run(mid_osc_run), .fast_osc_run(fast_osc_run),
    .main_mux_sel(main_mux_sel), .cpu_mux_sel(cpu_mux_sel),
    .clock_gate_off(clock_gate_off)
);
`default_nettype wire

// [verif/ccs_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_src_model
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // start-up speed, 0 prompt and 1 slow
    input  wire logic slow,
    // sources asked to run
    input  wire logic hs_on,
    input  wire logic sub_on,
    input  wire logic mid_on,
    input  wire logic fast_on,
    // stability back to the block
    output logic      hs_ready,
    output logic      sub_ready,
    output logic      mid_ready,
    output logic      fast_ready
);
    logic [3:0] on_vec;
    logic [5:0] lim;
    logic [5:0] cnt_reg [4];

    // a resonator needs a start-up time before it is usable
    assign on_vec = {hs_on, sub_on, mid_on, fast_on};
    assign lim = slow ? 6'h28 : 6'h03;
    assign hs_ready = cnt_reg[3] == lim;
    assign sub_ready = cnt_reg[2] == lim;
    assign mid_ready = cnt_reg[1] == lim;
    assign fast_ready = cnt_reg[0] == lim;

    // a stopped source loses stability at once
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
            if (!rst_n || !on_vec[i])
                cnt_reg[i] <= 6'h00;
            else if (cnt_reg[i] < lim)
                cnt_reg[i] <= cnt_reg[i] + 6'h01;
    end
endmodule // ccs_src_model
`default_nettype wire

// [verif/ccs_clock_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_ctrl_bench;
    import ccs_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        slow;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        hs_rdy, sub_rdy, mid_rdy, fast_rdy;
    logic        hs_run, hs_ext, hs_port, rng, sub_run, sub_ext, sub_port;
    logic [1:0]  drv;
    logic        mid_run, fast_run, onchip_sel, main_sel, cpu_sel, gate;
    logic        rd_d = 1'b0;
    logic [7:0]  exp_q [$];
    logic [7:0]  pm;
    logic [7:0]  rc;
    logic [7:0]  r;
    logic        a;
    logic        h;
    logic [1:0]  m;
    int          bad_count, n_compared, cycles;
    wire logic [10:0] pin_vec = {hs_run, hs_ext, hs_port, sub_run, sub_ext,
                                 sub_port, mid_run, fast_run, drv, rng};
    wire logic [10:0] mux_vec = {7'h00, gate, cpu_sel, main_sel, onchip_sel};

    ccs_clock_ctrl ccs_clock_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .hs_clock_ready(hs_rdy),
        .sub_clock_ready(sub_rdy), .fast_osc_ready(fast_rdy),
        .mid_osc_ready(mid_rdy), .hs_crystal_oscillator_run(hs_run),
        .hs_external_accept(hs_ext), .hs_port_mode(hs_port),
        .hs_freq_range(rng), .sub_crystal_oscillator_run(sub_run),
        .sub_external_accept(sub_ext), .sub_port_mode(sub_port),
        .sub_drive_mode(drv), .mid_osc_run(mid_run),
        .fast_osc_run(fast_run), .onchip_mux_sel(onchip_sel),
        .main_mux_sel(main_sel), .cpu_mux_sel(cpu_sel),
        .clock_gate_off(gate)
    );
    ccs_src_model ccs_src_model_inst (
        .clk(clk), .rst_n(rst_n), .slow(slow),
        .hs_on(hs_run | hs_ext), .sub_on(sub_run | sub_ext),
        .mid_on(mid_run), .fast_on(fast_run), .hs_ready(hs_rdy),
        .sub_ready(sub_rdy), .mid_ready(mid_rdy), .fast_ready(fast_rdy)
    );

    always #5 clk = ~clk;

    task automatic chk_val(input string nm, input logic [10:0] e,
                           input logic [10:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // the expectation is queued before the strobe goes out
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // bounded waits for the gate to close and open again
    task automatic sw_wait(input logic [10:0] e);
        repeat (100) if (gate !== 1'b1) @(posedge clk);
        repeat (20) if (gate !== 1'b0) @(posedge clk);
        repeat (2) @(posedge clk);
        chk_val("mux select", e, mux_vec);
    endtask

    task end_of_test;
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rd_d)
            chk_val("read data", {3'h0, exp_q.pop_front()},
                    {3'h0, reg_rdata});
        rd_d <= reg_rd;
    end

    // hang guard, far above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        slow = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        r = 8'($urandom(99657));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_val("reset pins", 11'h128, pin_vec);
        rd(PIN_MODE_OFFS, PIN_MODE_RESET);
        rd(RUN_CTRL_OFFS, RUN_CTRL_RESET);
        rd(SYS_SEL_OFFS, SYS_SEL_RESET);
        rd(8'h7F, 8'h00);
        // every pin code, with sources running and halted
        for (int i = 0; i < 8; i++)
        begin
            {m, h} = 3'(i);
            wr(RUN_CTRL_OFFS, {h, h, 6'h00});
            wr(PIN_MODE_OFFS, {m, m, 4'h0});
            repeat (3) @(posedge clk);
            chk_val("pins", {m == 2'h1 && !h, m == 2'h3 && !h,
                !m[0], m == 2'h1 && !h, m == 2'h3 && !h,
                !m[0], 5'h08}, pin_vec);
        end
        // drive codes, the barred one keeps the old field
        pm = 8'h00;
        for (int d = 0; d < 4; d++)
        begin
            r = {5'h00, 2'(d), 1'(d >> 1)};
            pm = {r[7:3], (d == 3) ? pm[2:1] : r[2:1], r[0]};
            wr(PIN_MODE_OFFS, r);
            repeat (3) @(posedge clk);
            chk_val("drive", {8'h25, pm[2:0]}, pin_vec);
            rd(PIN_MODE_OFFS, pm);
        end
        // random traffic on the pin mode and run control registers
        rc = 8'hC0;
        repeat (24)
        begin
            a = 1'($urandom);
            r = 8'($urandom);
            if (!a)
                pm = {r[7:4], 1'b0, (r[2:1] == 2'h3) ? pm[2:1] : r[2:1], r[0]};
            else
                rc = r & RUN_CTRL_MASK;
            wr(a ? RUN_CTRL_OFFS : PIN_MODE_OFFS, r);
            rd(a ? RUN_CTRL_OFFS : PIN_MODE_OFFS, a ? rc : pm);
        end
        // switchovers with slow sources
        wr(RUN_CTRL_OFFS, 8'hC1);
        slow <= 1'b1;
        wr(PIN_MODE_OFFS, 8'h50);
        wr(RUN_CTRL_OFFS, 8'h02);
        wr(SYS_SEL_OFFS, 8'h01);
        sw_wait(11'h001);
        rd(SYS_SEL_OFFS, 8'h03);
        wr(SYS_SEL_OFFS, 8'h11);
        sw_wait(11'h003);
        rd(SYS_SEL_OFFS, 8'h33);
        wr(SYS_SEL_OFFS, 8'hFF);
        sw_wait(11'h007);
        rd(SYS_SEL_OFFS, 8'hF3);
        wr(SYS_SEL_OFFS, 8'h11);
        sw_wait(11'h003);
        rd(SYS_SEL_OFFS, 8'h33);
        // a halted target never completes, status stays put
        wr(RUN_CTRL_OFFS, 8'h42);
        wr(SYS_SEL_OFFS, 8'h51);
        repeat (30) @(posedge clk);
        chk_val("stalled switch", 11'h003, mux_vec);
        rd(SYS_SEL_OFFS, 8'h73);
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule // ccs_clock_ctrl_bench
`default_nettype wire
